// ==== sdsr_pkg.sv ====
`default_nettype none
package sdsr_pkg;
  // serial word layout
  localparam int unsigned SDSR_WORD_W = 24;
  localparam int unsigned SDSR_DATA_W = 22;
  localparam int unsigned SDSR_ADDR_W = 2;
  localparam logic [1:0]  SDSR_ADDR_REF = 2'h2;
  localparam logic [1:0]  SDSR_ADDR_FB  = 2'h3;

  // reference register fields (data bit positions)
  localparam int unsigned SDSR_REF_DIV_LSB     = 0;
  localparam int unsigned SDSR_REF_DIV_W       = 15;
  localparam int unsigned SDSR_REF_SENSE_BIT   = 15;
  localparam int unsigned SDSR_REF_PUMP_LSB    = 16;
  localparam int unsigned SDSR_REF_PUMP_W      = 4;
  localparam int unsigned SDSR_REF_DOUBLER_BIT = 20;
  localparam int unsigned SDSR_REF_CAL_BIT     = 21;

  // feedback register fields (data bit positions)
  localparam int unsigned SDSR_FB_FRAC_LSB    = 0;
  localparam int unsigned SDSR_FB_FRAC_W      = 4;
  localparam int unsigned SDSR_FB_SWAL_LSB    = 4;
  localparam int unsigned SDSR_FB_SWAL_W      = 5;
  localparam int unsigned SDSR_FB_MAIN_LSB    = 9;
  localparam int unsigned SDSR_FB_MAIN_W      = 10;
  localparam int unsigned SDSR_FB_MODULUS_BIT = 19;
  localparam int unsigned SDSR_FB_SLEEP_BIT   = 20;
  localparam int unsigned SDSR_FB_CLEAR_BIT   = 21;

  // reset values
  localparam logic [21:0] SDSR_REF_RESET = 22'h000000;
  localparam logic [21:0] SDSR_FB_RESET  = 22'h000000;

  // charge pump current step, microamps per code step
  localparam int unsigned SDSR_PUMP_STEP_UA = 100;
endpackage
`default_nettype wire

// ==== sdsr_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// carries the shifted word from the serial-clock side to the core
interface sdsr_link_if import sdsr_pkg::*; ();
  logic [SDSR_WORD_W-1:0] word;
  modport shifter (output word);
  modport core    (input word);
endinterface
`default_nettype wire

// ==== sdsr_shifter.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdsr_shifter import sdsr_pkg::*; (
  // serial side
  input  wire logic         ser_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ser_data_i,
  // word towards the core
  sdsr_link_if.shifter      link
);
  logic [SDSR_WORD_W-1:0] shift_reg;
  logic [SDSR_WORD_W-1:0] shift_next;

  // msb first: newest bit enters at bit 0, address ends in bits 1:0
  assign shift_next = {shift_reg[SDSR_WORD_W-2:0], ser_data_i};
  assign link.word  = shift_reg;

  // one bit per rising serial clock; never gated by sleep
  always_ff @(posedge ser_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 24'h000000;
    end else begin
      shift_reg <= shift_next;
    end
  end
endmodule // sdsr_shifter
`default_nettype wire

// ==== sdsr_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - strobe rise with address 10 loads the 22 data bits as reference config
// - words arrive msb first, address ends up in bits 1 and 0
// - reference divisor is data bits 14:0; reference counter divides oscillator by it
// - reference bit 20 switches the pump supply doubler on or off
// - reference bit 21 picks calibration speed, one is fast, host sets one
// - reference bits 19:16 give pump current of 100 uA times code plus one
// - strobe rise with address 11 loads the 22 data bits as feedback control
// - feedback fields: fraction 3:0, swallow 8:4, main 18:9, control 21:19
// - feedback bit 19 picks prescaler modulus, zero 16/17, one 32/33
// - feedback bit 20 sleeps: counters stop, pump and detector outputs float
// - feedback bit 21 holds both counters reset; release restarts them together
// - shifting and latching keep working while asleep
module sdsr_regs import sdsr_pkg::*; (
  // core clock and reset
  input  wire logic                    CLOCK_I,
  input  wire logic                    RST_I,
  // three-wire programming link
  input  wire logic                    SER_CLK_I,
  input  wire logic                    SER_DATA_I,
  input  wire logic                    WORD_STROBE_I,
  // divider inputs from the analogue front end
  input  wire logic                    OSC_I,
  input  wire logic                    PRESCALER_I,
  // programmed registers
  output logic [SDSR_DATA_W-1:0]       REF_CONFIG_O,
  output logic [SDSR_DATA_W-1:0]       FB_CONTROL_O,
  // decoded controls
  output logic                         PUMP_DOUBLER_ON_O,
  output logic                         CAL_FAST_O,
  output logic [SDSR_REF_PUMP_W:0]     PUMP_CURRENT_STEPS_O,
  output logic                         MODULUS_CHOICE_O,
  output logic                         SLEEP_REQUEST_O,
  output logic                         DIVIDER_CLEAR_O,
  // divider activity
  output logic                         MODULUS_HIGH_O,
  output logic                         REF_TICK_O,
  output logic                         FB_TICK_O,
  // phase detector pump drive, three-state
  output logic                         PUMP_UP_O,
  output logic                         PUMP_UP_OE_O,
  output logic                         PUMP_DN_O,
  output logic                         PUMP_DN_OE_O
);

  // counter terminal test, shared by reference and main counters
  function automatic logic at_last(input logic [15:0] cnt, input logic [15:0] lim);
    at_last = (cnt + 16'h0001) >= lim;
  endfunction

  // ------------------------------------------------------------
  // serial side: shifter runs on the link clock
  // ------------------------------------------------------------
  sdsr_link_if link ();

  sdsr_shifter u_shifter (
    .ser_clk_i  (SER_CLK_I),
    .rst_i      (RST_I),
    .ser_data_i (SER_DATA_I),
    .link       (link.shifter)
  );

  // ------------------------------------------------------------
  // strobe crossing into the core clock
  // ------------------------------------------------------------
  logic strobe_s1_reg;
  logic strobe_s2_reg;
  logic strobe_s3_reg;
  wire  strobe_rise;

  // first stage only feeds the second
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
    end else begin
      strobe_s1_reg <= WORD_STROBE_I;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
    end
  end

  assign strobe_rise = strobe_s2_reg & ~strobe_s3_reg;

  // ------------------------------------------------------------
  // address decode and register load
  // ------------------------------------------------------------
  // the word is quasi-static here: the serial clock stands still while
  // the strobe is high, so the sync delay gives it time to settle
  wire [SDSR_ADDR_W-1:0] word_addr;
  wire [SDSR_DATA_W-1:0] word_data;
  wire                   load_ref;
  wire                   load_fb;

  assign word_addr = link.word[SDSR_ADDR_W-1:0];
  assign word_data = link.word[SDSR_WORD_W-1:SDSR_ADDR_W];
  assign load_ref  = strobe_rise & (word_addr == SDSR_ADDR_REF);
  assign load_fb   = strobe_rise & (word_addr == SDSR_ADDR_FB);

  logic [SDSR_DATA_W-1:0] ref_cfg_reg;
  logic [SDSR_DATA_W-1:0] fb_cfg_reg;
  wire  [SDSR_DATA_W-1:0] ref_cfg_next;
  wire  [SDSR_DATA_W-1:0] fb_cfg_next;

  // addresses 00 and 01 fall through and change nothing here
  assign ref_cfg_next = load_ref ? word_data : ref_cfg_reg;
  assign fb_cfg_next  = load_fb  ? word_data : fb_cfg_reg;

  // loading is never blocked by sleep or counter clear
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_cfg_reg <= SDSR_REF_RESET;
      fb_cfg_reg  <= SDSR_FB_RESET;
    end else begin
      ref_cfg_reg <= ref_cfg_next;
      fb_cfg_reg  <= fb_cfg_next;
    end
  end

  // ------------------------------------------------------------
  // field split
  // ------------------------------------------------------------
  wire [SDSR_REF_DIV_W-1:0]  reference_divisor;
  wire                       phase_sense_select;
  wire [SDSR_REF_PUMP_W-1:0] pump_setting_field;
  wire                       pump_doubler_on;
  wire                       cal_fast;
  wire [SDSR_FB_FRAC_W-1:0]  fraction_numerator;
  wire [SDSR_FB_SWAL_W-1:0]  swallow_count;
  wire [SDSR_FB_MAIN_W-1:0]  main_count;
  wire                       modulus_choice;
  wire                       sleep_request;
  wire                       divider_clear;

  assign reference_divisor  = ref_cfg_reg[SDSR_REF_DIV_LSB +: SDSR_REF_DIV_W];
  assign phase_sense_select = ref_cfg_reg[SDSR_REF_SENSE_BIT];
  assign pump_setting_field = ref_cfg_next[SDSR_REF_PUMP_LSB +: SDSR_REF_PUMP_W];
  assign pump_doubler_on    = ref_cfg_reg[SDSR_REF_DOUBLER_BIT];
  assign cal_fast           = ref_cfg_reg[SDSR_REF_CAL_BIT];
  assign fraction_numerator = fb_cfg_reg[SDSR_FB_FRAC_LSB +: SDSR_FB_FRAC_W];
  assign swallow_count      = fb_cfg_reg[SDSR_FB_SWAL_LSB +: SDSR_FB_SWAL_W];
  assign main_count         = fb_cfg_reg[SDSR_FB_MAIN_LSB +: SDSR_FB_MAIN_W];
  assign modulus_choice     = fb_cfg_reg[SDSR_FB_MODULUS_BIT];
  assign sleep_request      = fb_cfg_reg[SDSR_FB_SLEEP_BIT];
  assign divider_clear      = fb_cfg_reg[SDSR_FB_CLEAR_BIT];

  // counters run only when neither asleep nor cleared
  wire run;
  assign run = ~sleep_request & ~divider_clear;

  // ------------------------------------------------------------
  // oscillator and prescaler pulse inputs, two-stage synced
  // ------------------------------------------------------------
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic pre_s1_reg;
  logic pre_s2_reg;
  logic pre_s3_reg;
  wire  osc_tick;
  wire  pre_tick;

  // limitation: inputs must be slower than half the core clock
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      pre_s1_reg <= 1'b0;
      pre_s2_reg <= 1'b0;
      pre_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= OSC_I;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      pre_s1_reg <= PRESCALER_I;
      pre_s2_reg <= pre_s1_reg;
      pre_s3_reg <= pre_s2_reg;
    end
  end

  assign osc_tick = osc_s2_reg & ~osc_s3_reg;
  assign pre_tick = pre_s2_reg & ~pre_s3_reg;

  // ------------------------------------------------------------
  // reference counter
  // ------------------------------------------------------------
  logic [SDSR_REF_DIV_W-1:0] ref_cnt_reg;
  logic [SDSR_REF_DIV_W-1:0] ref_cnt_next;
  wire                       ref_last;
  wire                       ref_event;

  // divisor of 0 is the host's fault; no trap, it just divides by one
  assign ref_last     = at_last({1'b0, ref_cnt_reg}, {1'b0, reference_divisor});
  assign ref_event    = run & osc_tick & ref_last;
  assign ref_cnt_next = !run      ? 15'h0000 :
                        !osc_tick ? ref_cnt_reg :
                        ref_last  ? 15'h0000 :
                        ref_cnt_reg + 15'h0001;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_cnt_reg <= 15'h0000;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // feedback counter: main, swallow and fraction accumulator
  // ------------------------------------------------------------
  logic [SDSR_FB_MAIN_W:0]   main_cnt_reg;
  logic [SDSR_FB_MAIN_W:0]   main_cnt_next;
  logic [SDSR_FB_SWAL_W-1:0] swal_cnt_reg;
  logic [SDSR_FB_SWAL_W-1:0] swal_cnt_next;
  logic [SDSR_FB_FRAC_W-1:0] frac_acc_reg;
  logic [SDSR_FB_FRAC_W-1:0] frac_acc_next;
  logic                      extend_reg;
  logic                      extend_next;
  wire  [SDSR_FB_MAIN_W:0]   main_target;
  wire  [SDSR_FB_FRAC_W:0]   frac_sum;
  wire                       main_last;
  wire                       fb_event;

  // a carry out of the fraction stretches the next cycle by one count
  assign main_target = {1'b0, main_count} + {{SDSR_FB_MAIN_W{1'b0}}, extend_reg};
  assign main_last   = at_last({5'h00, main_cnt_reg}, {5'h00, main_target});
  assign fb_event    = run & pre_tick & main_last;
  assign frac_sum    = {1'b0, frac_acc_reg} + {1'b0, fraction_numerator};

  // cleared state reloads, so release starts in step with the reference
  assign main_cnt_next = !run      ? 11'h000 :
                         !pre_tick ? main_cnt_reg :
                         main_last ? 11'h000 :
                         main_cnt_reg + 11'h001;
  assign swal_cnt_next = (!run || (pre_tick && main_last)) ? swallow_count :
                         (pre_tick && (swal_cnt_reg != 5'h00)) ? swal_cnt_reg - 5'h01 :
                         swal_cnt_reg;
  assign frac_acc_next = !run     ? 4'h0 :
                         fb_event ? frac_sum[SDSR_FB_FRAC_W-1:0] :
                         frac_acc_reg;
  assign extend_next   = !run     ? 1'b0 :
                         fb_event ? frac_sum[SDSR_FB_FRAC_W] :
                         extend_reg;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      main_cnt_reg <= 11'h000;
      swal_cnt_reg <= 5'h00;
      frac_acc_reg <= 4'h0;
      extend_reg   <= 1'b0;
    end else begin
      main_cnt_reg <= main_cnt_next;
      swal_cnt_reg <= swal_cnt_next;
      frac_acc_reg <= frac_acc_next;
      extend_reg   <= extend_next;
    end
  end

  // ------------------------------------------------------------
  // phase detector
  // ------------------------------------------------------------
  logic ref_lead_reg;
  logic fb_lead_reg;
  wire  ref_lead_set;
  wire  fb_lead_set;
  wire  ref_lead_next;
  wire  fb_lead_next;
  wire  up_next;
  wire  dn_next;

  // both seen: reset pair, the usual frequency-phase detector
  assign ref_lead_set  = ref_lead_reg | ref_event;
  assign fb_lead_set   = fb_lead_reg | fb_event;
  assign ref_lead_next = run & ref_lead_set & ~fb_lead_set;
  assign fb_lead_next  = run & fb_lead_set & ~ref_lead_set;
  // sense bit swaps pump direction to suit the tuning slope
  assign up_next = phase_sense_select ? ref_lead_next : fb_lead_next;
  assign dn_next = phase_sense_select ? fb_lead_next : ref_lead_next;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ref_lead_reg <= 1'b0;
      fb_lead_reg  <= 1'b0;
    end else begin
      ref_lead_reg <= ref_lead_next;
      fb_lead_reg  <= fb_lead_next;
    end
  end

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  wire [SDSR_REF_PUMP_W:0] pump_steps;

  // current in 100 uA steps is code plus one; taken from the next word so it
  // moves in the same cycle as the stored word, not one behind
  assign pump_steps = {1'b0, pump_setting_field} + 5'h01;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      REF_CONFIG_O         <= SDSR_REF_RESET;
      FB_CONTROL_O         <= SDSR_FB_RESET;
      PUMP_DOUBLER_ON_O    <= 1'b0;
      CAL_FAST_O           <= 1'b0;
      PUMP_CURRENT_STEPS_O <= 5'h01;
      MODULUS_CHOICE_O     <= 1'b0;
      SLEEP_REQUEST_O      <= 1'b0;
      DIVIDER_CLEAR_O      <= 1'b0;
    end else begin
      REF_CONFIG_O         <= ref_cfg_next;
      FB_CONTROL_O         <= fb_cfg_next;
      PUMP_DOUBLER_ON_O    <= ref_cfg_next[SDSR_REF_DOUBLER_BIT];
      CAL_FAST_O           <= ref_cfg_next[SDSR_REF_CAL_BIT];
      PUMP_CURRENT_STEPS_O <= pump_steps;
      MODULUS_CHOICE_O     <= fb_cfg_next[SDSR_FB_MODULUS_BIT];
      SLEEP_REQUEST_O      <= fb_cfg_next[SDSR_FB_SLEEP_BIT];
      DIVIDER_CLEAR_O      <= fb_cfg_next[SDSR_FB_CLEAR_BIT];
    end
  end

  // divider activity and pump drive; pump floats while asleep
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      MODULUS_HIGH_O <= 1'b0;
      REF_TICK_O     <= 1'b0;
      FB_TICK_O      <= 1'b0;
      PUMP_UP_O      <= 1'b0;
      PUMP_DN_O      <= 1'b0;
      PUMP_UP_OE_O   <= 1'b0;
      PUMP_DN_OE_O   <= 1'b0;
    end else begin
      MODULUS_HIGH_O <= run & (swal_cnt_next != 5'h00);
      REF_TICK_O     <= ref_event;
      FB_TICK_O      <= fb_event;
      PUMP_UP_O      <= up_next;
      PUMP_DN_O      <= dn_next;
      PUMP_UP_OE_O   <= ~sleep_request;
      PUMP_DN_OE_O   <= ~sleep_request;
    end
  end

endmodule // sdsr_regs
`default_nettype wire

// ==== sdsr_regs_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdsr_regs_checker import sdsr_pkg::*; (
  // clock and reset
  input  wire logic                     CLOCK_I,
  input  wire logic                     RST_I,
  // link strobe
  input  wire logic                     WORD_STROBE_I,
  // stored words and decoded controls
  input  wire logic [SDSR_DATA_W-1:0]   REF_CONFIG_O,
  input  wire logic [SDSR_DATA_W-1:0]   FB_CONTROL_O,
  input  wire logic                     PUMP_DOUBLER_ON_O,
  input  wire logic                     CAL_FAST_O,
  input  wire logic [SDSR_REF_PUMP_W:0] PUMP_CURRENT_STEPS_O,
  input  wire logic                     MODULUS_CHOICE_O,
  input  wire logic                     SLEEP_REQUEST_O,
  input  wire logic                     DIVIDER_CLEAR_O,
  // divider and pump activity
  input  wire logic                     REF_TICK_O,
  input  wire logic                     FB_TICK_O,
  input  wire logic                     PUMP_UP_O,
  input  wire logic                     PUMP_DN_O,
  input  wire logic                     PUMP_UP_OE_O,
  input  wire logic                     PUMP_DN_OE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  // decoded outputs always mirror the stored words
  chk_pump_steps: assert property (
    PUMP_CURRENT_STEPS_O == {1'b0, REF_CONFIG_O[19:16]} + 5'h01) else $error("pump steps off");
  chk_ref_bits: assert property (
    PUMP_DOUBLER_ON_O == REF_CONFIG_O[20] && CAL_FAST_O == REF_CONFIG_O[21])
    else $error("reference control bits off");
  chk_fb_bits: assert property (
    {DIVIDER_CLEAR_O, SLEEP_REQUEST_O, MODULUS_CHOICE_O} == FB_CONTROL_O[21:19])
    else $error("feedback control bits off");
  // registers only move around a latch
  chk_idle_stable: assert property (
    !WORD_STROBE_I [*8] |-> $stable(REF_CONFIG_O) && $stable(FB_CONTROL_O))
    else $error("register changed without a latch");
  // one cycle lag allowed, outputs are registered
  chk_sleep_float: assert property (
    SLEEP_REQUEST_O && $past(SLEEP_REQUEST_O) |-> !PUMP_UP_OE_O && !PUMP_DN_OE_O)
    else $error("pump driven while asleep");
  chk_awake_drive: assert property (
    !SLEEP_REQUEST_O && !$past(SLEEP_REQUEST_O) && !$past(RST_I) |-> PUMP_UP_OE_O && PUMP_DN_OE_O)
    else $error("pump floating while awake");
  chk_sleep_quiet: assert property (
    SLEEP_REQUEST_O [*3] |-> !REF_TICK_O && !FB_TICK_O && !PUMP_UP_O && !PUMP_DN_O)
    else $error("activity while asleep");
  chk_clear_hold: assert property (
    DIVIDER_CLEAR_O [*3] |-> !REF_TICK_O && !FB_TICK_O && !PUMP_UP_O && !PUMP_DN_O)
    else $error("activity while counters cleared");
  chk_tick_pulse: assert property (
    REF_TICK_O |=> !REF_TICK_O) else $error("reference tick too long");

  // main scenarios reached
  cov_sleep: cover property (SLEEP_REQUEST_O [*3]);
  cov_clear: cover property (DIVIDER_CLEAR_O [*3]);
  cov_ref_tick: cover property (REF_TICK_O);
  cov_fb_tick: cover property (FB_TICK_O);
endmodule // sdsr_regs_checker

bind sdsr_regs sdsr_regs_checker u_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .WORD_STROBE_I(WORD_STROBE_I),
  .REF_CONFIG_O(REF_CONFIG_O), .FB_CONTROL_O(FB_CONTROL_O),
  .PUMP_DOUBLER_ON_O(PUMP_DOUBLER_ON_O), .CAL_FAST_O(CAL_FAST_O),
  .PUMP_CURRENT_STEPS_O(PUMP_CURRENT_STEPS_O), .MODULUS_CHOICE_O(MODULUS_CHOICE_O),
  .SLEEP_REQUEST_O(SLEEP_REQUEST_O), .DIVIDER_CLEAR_O(DIVIDER_CLEAR_O),
  .REF_TICK_O(REF_TICK_O), .FB_TICK_O(FB_TICK_O), .PUMP_UP_O(PUMP_UP_O),
  .PUMP_DN_O(PUMP_DN_O), .PUMP_UP_OE_O(PUMP_UP_OE_O), .PUMP_DN_OE_O(PUMP_DN_OE_O)
);
`default_nettype wire

// ==== sdsr_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdsr_host_model import sdsr_pkg::*; (
  // three-wire programming link
  output logic SER_CLK_O,
  output logic SER_DATA_O,
  output logic WORD_STROBE_O
);
  localparam int HALF_NS = 32;
  // clock parked low between frames
  initial begin
    SER_CLK_O = 1'b0;
    SER_DATA_O = 1'b1;
    WORD_STROBE_O = 1'b0;
  end
  // one word msb first, address last; odd start keeps phase unrelated to core clock
  task automatic send_word(input logic [SDSR_WORD_W-1:0] w);
    #3;
    for (int i = SDSR_WORD_W - 1; i >= 0; i--) begin
      SER_DATA_O = w[i];
      #HALF_NS SER_CLK_O = 1'b1;
      #HALF_NS SER_CLK_O = 1'b0;
    end
    // released data line shows the inverse, never a stale bit
    #HALF_NS SER_DATA_O = ~SER_DATA_O;
    WORD_STROBE_O = 1'b1;
    #(4 * HALF_NS) WORD_STROBE_O = 1'b0; // far above four core cycles
    #(2 * HALF_NS);
  endtask
endmodule // sdsr_host_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top import sdsr_pkg::*; ;
  logic                     clk;
  logic                     rst;
  logic                     osc;
  logic                     presc;
  logic                     ser_clk;
  logic                     ser_data;
  logic                     strobe;
  logic [SDSR_DATA_W-1:0]   ref_cfg;
  logic [SDSR_DATA_W-1:0]   fb_ctl;
  logic                     doubler;
  logic                     cal_fast;
  logic [SDSR_REF_PUMP_W:0] steps;
  logic                     modsel;
  logic                     sleep;
  logic                     clear;
  logic                     ref_tick;
  logic                     fb_tick;
  logic                     up;
  logic                     up_oe;
  logic                     dn;
  logic                     dn_oe;
  logic                     mod_high;
  int                       error_cnt = 0;
  int                       n_checks = 0;
  int                       ref_ticks = 0;
  int                       fb_ticks = 0;

  sdsr_host_model host (.SER_CLK_O(ser_clk), .SER_DATA_O(ser_data), .WORD_STROBE_O(strobe));

  sdsr_regs dut (
    .CLOCK_I(clk), .RST_I(rst), .SER_CLK_I(ser_clk), .SER_DATA_I(ser_data),
    .WORD_STROBE_I(strobe), .OSC_I(osc), .PRESCALER_I(presc), .REF_CONFIG_O(ref_cfg),
    .FB_CONTROL_O(fb_ctl), .PUMP_DOUBLER_ON_O(doubler), .CAL_FAST_O(cal_fast),
    .PUMP_CURRENT_STEPS_O(steps), .MODULUS_CHOICE_O(modsel), .SLEEP_REQUEST_O(sleep),
    .DIVIDER_CLEAR_O(clear), .MODULUS_HIGH_O(mod_high),
    .REF_TICK_O(ref_tick), .FB_TICK_O(fb_tick),
    .PUMP_UP_O(up), .PUMP_UP_OE_O(up_oe), .PUMP_DN_O(dn), .PUMP_DN_OE_O(dn_oe)
  );

  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // tick counters, compared as deltas
  always @(posedge clk) begin
    ref_ticks <= ref_ticks + int'(ref_tick === 1'b1);
    fb_ticks <= fb_ticks + int'(fb_tick === 1'b1);
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_word(input logic [21:0] got, input logic [21:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // latch lands 2 to 3 cycles after the strobe; 8 leaves margin
  task automatic write_word(input logic [21:0] data, input logic [1:0] addr);
    host.send_word({data, addr});
    repeat (8) @(negedge clk);
  endtask

  // both inputs high 3 and low 3 cycles, comfortably over the 2-cycle minimum
  task automatic pulse_inputs(input int n_osc, input int n_pre);
    for (int i = 0; i < n_osc || i < n_pre; i++) begin
      @(negedge clk);
      osc = (i < n_osc);
      presc = (i < n_pre);
      repeat (3) @(negedge clk);
      osc = 1'b0;
      presc = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (8) @(negedge clk);
  endtask

  // hang guard
  initial begin
    #900000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    logic [21:0] last_ref;
    logic [21:0] fbw;
    int          r0;
    int          f0;
    rst = 1'b1;
    osc = 1'b0;
    presc = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check_word(ref_cfg, SDSR_REF_RESET);
    check_word(fb_ctl, SDSR_FB_RESET);
    check_word({17'h0, steps}, 22'h000001);
    check_bit(up_oe, 1'b1);
    // every pump code, doubler toggled alongside
    for (int c = 0; c < 16; c++) begin
      last_ref = {1'b1, c[0], c[3:0], 1'b1, 15'h0003};
      write_word(last_ref, SDSR_ADDR_REF);
      check_word(ref_cfg, last_ref);
      check_word({17'h0, steps}, 22'(c + 1));
      check_bit(doubler, c[0]);
      check_bit(cal_fast, 1'b1);
    end
    // addresses 00 and 01 touch nothing
    for (int a = 0; a < 2; a++) begin
      write_word(22'h3FFFFF, a[1:0]);
      check_word(ref_cfg, last_ref);
      check_word(fb_ctl, SDSR_FB_RESET);
    end
    // both prescaler moduli
    for (int m = 0; m < 2; m++) begin
      fbw = {2'b00, m[0], 10'h003, 5'h01, 4'h9};
      write_word(fbw, SDSR_ADDR_FB);
      check_word(fb_ctl, fbw);
      check_bit(modsel, m[0]);
      check_word(ref_cfg, last_ref);
    end
    // counters held while clear is set, pump still driven
    fbw = {3'b100, 10'h003, 5'h01, 4'h0};
    write_word(fbw, SDSR_ADDR_FB);
    check_bit(clear, 1'b1);
    r0 = ref_ticks;
    f0 = fb_ticks;
    pulse_inputs(6, 6);
    check_word(22'(ref_ticks - r0), 22'h000000);
    check_word(22'(fb_ticks - f0), 22'h000000);
    check_bit(up_oe, 1'b1);
    check_bit(mod_high, 1'b0);
    // release: both restart from zero together
    fbw[21] = 1'b0;
    write_word(fbw, SDSR_ADDR_FB);
    r0 = ref_ticks;
    f0 = fb_ticks;
    pulse_inputs(9, 6);
    check_word(22'(ref_ticks - r0), 22'h000003);
    check_word(22'(fb_ticks - f0), 22'h000002);
    // last reference tick ran alone: sense high drives up
    check_bit(up, 1'b1);
    check_bit(dn, 1'b0);
    check_bit(mod_high, 1'b1);
    // sleep floats the pump and stops the reference counter
    fbw[20] = 1'b1;
    write_word(fbw, SDSR_ADDR_FB);
    check_bit(up_oe, 1'b0);
    check_bit(dn_oe, 1'b0);
    r0 = ref_ticks;
    pulse_inputs(6, 6);
    check_word(22'(ref_ticks - r0), 22'h000000);
    // link keeps latching while asleep
    last_ref = {1'b1, 1'b0, 4'h1, 1'b0, 15'h0005};
    write_word(last_ref, SDSR_ADDR_REF);
    check_word(ref_cfg, last_ref);
    check_word({17'h0, steps}, 22'h000002);
    // wake, new divisor of 5
    fbw[20] = 1'b0;
    write_word(fbw, SDSR_ADDR_FB);
    check_bit(up_oe, 1'b1);
    r0 = ref_ticks;
    pulse_inputs(10, 0);
    check_word(22'(ref_ticks - r0), 22'h000002);
    // reference leads with sense low: pump drives down
    check_bit(dn, 1'b1);
    check_bit(up, 1'b0);
    check_bit(mod_high, 1'b1);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
